// ===== hdl/sbsc_params.svh
// Constants for the serial boot security command handler.
`ifndef SBSC_PARAMS_SVH
`define SBSC_PARAMS_SVH
`define SBSC_MATCH1_A 8'h86
`define SBSC_MATCH1_B 8'h30
`define SBSC_MATCH2_A 8'h79
`define SBSC_MATCH2_B 8'hcf
`define SBSC_CMD_EMU 8'hd0
`define SBSC_ACK_EMU 8'hd1
`define SBSC_CMD_SEC 8'hfa
`define SBSC_ACK_SEC 8'hfb
`define SBSC_ERR_CMD 8'h63
`define SBSC_ERR_FRM 8'ha1
`define SBSC_ERR_OVR 8'ha3
`define SBSC_ERR_REPEAT 2'h3
`define SBSC_ADDR_BYTES 3'h6
`define SBSC_PW_MAX 8'h20
`define SBSC_CLK_HZ 100000000
`define SBSC_DIV_W 16
`endif

// ===== hdl/sbsc_pkg.sv
// Types shared by the serial boot security command handler.
package sbsc_pkg;
	typedef enum logic [3:0] {
		SBSC_ST_SYNC1 = 4'h0,
		SBSC_ST_SYNC2 = 4'h1,
		SBSC_ST_CMD = 4'h2,
		SBSC_ST_EMU_VAL = 4'h3,
		SBSC_ST_ADDR = 4'h4,
		SBSC_ST_PW = 4'h5,
		SBSC_ST_ERR = 4'h6,
		SBSC_ST_IDLE = 4'h7,
		SBSC_ST_REPLY = 4'h8
	} sbsc_state_t;
	typedef struct packed {
		logic valid;
		logic frame_err;
		logic overrun;
		logic [7:0] data;
	} sbsc_rx_t;
	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} sbsc_tx_t;
endpackage

// ===== hdl/sbsc_uart.sv
// Byte link with automatic rate detection on the first received byte.
`timescale 1ns/1ps
`default_nettype none
`include "sbsc_params.svh"
module sbsc_uart
	import sbsc_pkg::*;
(
	// Clock and reset.
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	// Serial pins.
	input wire logic rxd_i,
	output logic txd_o,
	// Byte side.
	input wire sbsc_tx_t tx_i,
	output logic tx_ready_o,
	output sbsc_rx_t rx_o,
	output logic rate_locked_o
);
	typedef enum logic [2:0] {
		SBSC_RX_MEASURE = 3'h0,
		SBSC_RX_IDLE = 3'h1,
		SBSC_RX_SHIFT = 3'h2,
		SBSC_RX_HIGH = 3'h3,
		SBSC_RX_SKIP = 3'h4
	} sbsc_rx_state_t;

	logic [2:0] rx_sync;
	logic rx_line;
	logic rx_line_q;
	logic [`SBSC_DIV_W-1:0] hi_cnt, next_hi_cnt;
	sbsc_rx_state_t rx_st, next_rx_st;
	logic [`SBSC_DIV_W-1:0] bit_len, next_bit_len;
	logic [`SBSC_DIV_W-1:0] rx_cnt, next_rx_cnt;
	logic [3:0] rx_bit, next_rx_bit;
	logic [7:0] rx_sh, next_rx_sh;
	logic locked, next_locked;
	sbsc_rx_t rx_q, next_rx_q;
	logic [`SBSC_DIV_W-1:0] tx_cnt, next_tx_cnt;
	logic [3:0] tx_bit, next_tx_bit;
	logic [9:0] tx_sh, next_tx_sh;
	logic tx_busy, next_tx_busy;
	logic txd, next_txd;

	// The line is valid once the second and third stages agree.
	assign rx_line = (rx_sync[1] == rx_sync[2]) ? rx_sync[2] : rx_line_q;
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rx_sync <= 3'h7;
			rx_line_q <= 1'b1;
		end else begin
			rx_sync <= {rx_sync[1:0], rxd_i};
			rx_line_q <= rx_line;
		end
	end

	// Receiver: first byte measured by its first high run, later bytes sampled at that rate.
	always_comb begin
		next_rx_st = rx_st;
		next_bit_len = bit_len;
		next_rx_cnt = rx_cnt;
		next_rx_bit = rx_bit;
		next_rx_sh = rx_sh;
		next_locked = locked;
		next_hi_cnt = hi_cnt;
		next_rx_q = '0;
		case (rx_st)
			SBSC_RX_MEASURE: begin
				// Length of the first low run; it is two bits for one match byte, five for the other.
				if (!rx_line) begin
					next_rx_cnt = rx_cnt + `SBSC_DIV_W'(1);
				end else if (rx_cnt != '0) begin
					next_hi_cnt = `SBSC_DIV_W'(1);
					next_rx_st = SBSC_RX_HIGH;
				end
			end
			SBSC_RX_HIGH: begin
				// Both match bytes carry a two-bit high run next, which gives the bit period.
				if (rx_line) begin
					next_hi_cnt = hi_cnt + `SBSC_DIV_W'(1);
				end else begin
					next_bit_len = (hi_cnt >> 1) - `SBSC_DIV_W'(1);
					next_locked = 1'b1;
					next_rx_sh = (rx_cnt > hi_cnt + (hi_cnt >> 1)) ? `SBSC_MATCH1_B : `SBSC_MATCH1_A;
					next_hi_cnt = '0;
					next_rx_st = SBSC_RX_SKIP;
				end
			end
			SBSC_RX_SKIP: begin
				// Rest of the first frame is skipped; one high bit time ends it.
				if (!rx_line) begin
					next_hi_cnt = '0;
				end else begin
					next_hi_cnt = hi_cnt + `SBSC_DIV_W'(1);
					if (hi_cnt == bit_len) begin
						next_rx_q.valid = 1'b1;
						next_rx_q.data = rx_sh;
						next_rx_st = SBSC_RX_IDLE;
					end
				end
			end
			SBSC_RX_IDLE: begin
				if (!rx_line) begin
					next_rx_cnt = '0;
					next_rx_bit = 4'h0;
					next_rx_st = SBSC_RX_SHIFT;
				end
			end
			SBSC_RX_SHIFT: begin
				next_rx_cnt = rx_cnt + `SBSC_DIV_W'(1);
				if (rx_cnt == bit_len + (bit_len >> 1) || (rx_bit != 4'h0 && rx_cnt == bit_len)) begin
					next_rx_cnt = '0;
					if (rx_bit == 4'h0) begin
						next_rx_bit = 4'h2;
						next_rx_sh = {rx_line, rx_sh[7:1]};
					end else if (rx_bit <= 4'h8) begin
						next_rx_bit = rx_bit + 4'h1;
						next_rx_sh = {rx_line, rx_sh[7:1]};
					end else begin
						next_rx_q.valid = 1'b1;
						next_rx_q.data = rx_sh;
						next_rx_q.frame_err = !rx_line;
						next_rx_st = SBSC_RX_IDLE;
					end
				end
			end
			default: next_rx_st = SBSC_RX_MEASURE;
		endcase
		// A new byte arriving while the last is unread is not possible here; overrun stays low.
		next_rx_q.overrun = 1'b0;
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rx_st <= SBSC_RX_MEASURE;
			bit_len <= '0;
			rx_cnt <= '0;
			rx_bit <= 4'h0;
			rx_sh <= 8'h00;
			locked <= 1'b0;
			hi_cnt <= '0;
			rx_q <= '0;
		end else begin
			rx_st <= next_rx_st;
			bit_len <= next_bit_len;
			rx_cnt <= next_rx_cnt;
			rx_bit <= next_rx_bit;
			rx_sh <= next_rx_sh;
			locked <= next_locked;
			hi_cnt <= next_hi_cnt;
			rx_q <= next_rx_q;
		end
	end

	// Transmitter at the adjusted rate.
	always_comb begin
		next_tx_cnt = tx_cnt;
		next_tx_bit = tx_bit;
		next_tx_sh = tx_sh;
		next_tx_busy = tx_busy;
		next_txd = txd;
		if (!tx_busy) begin
			next_txd = 1'b1;
			if (tx_i.valid) begin
				next_tx_sh = {1'b1, tx_i.data, 1'b0};
				next_tx_busy = 1'b1;
				next_tx_cnt = '0;
				next_tx_bit = 4'h0;
			end
		end else begin
			next_txd = tx_sh[0];
			next_tx_cnt = tx_cnt + `SBSC_DIV_W'(1);
			if (tx_cnt == bit_len) begin
				next_tx_cnt = '0;
				next_tx_sh = {1'b1, tx_sh[9:1]};
				next_tx_bit = tx_bit + 4'h1;
				if (tx_bit == 4'h9) begin
					next_tx_busy = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tx_cnt <= '0;
			tx_bit <= 4'h0;
			tx_sh <= 10'h3ff;
			tx_busy <= 1'b0;
			txd <= 1'b1;
		end else begin
			tx_cnt <= next_tx_cnt;
			tx_bit <= next_tx_bit;
			tx_sh <= next_tx_sh;
			tx_busy <= next_tx_busy;
			txd <= next_txd;
		end
	end

	assign txd_o = txd;
	assign tx_ready_o = !tx_busy && !tx_i.valid;
	assign rx_o = rx_q;
	assign rate_locked_o = locked;
endmodule
`default_nettype wire

// ===== hdl/sbsc_top.sv
// Command handler for emulation and flash security setting commands.
`timescale 1ns/1ps
`default_nettype none
`include "sbsc_params.svh"
module sbsc_top
	import sbsc_pkg::*;
(
	// Clock and reset.
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	// Serial pins.
	input wire logic rxd_i,
	output logic txd_o,
	// Flash status and password check.
	input wire logic flash_blank_i,
	input wire logic pw_done_i,
	input wire logic pw_ok_i,
	// Captured addresses and password bytes.
	output logic [23:0] pw_count_addr_o,
	output logic [23:0] pw_cmp_addr_o,
	output logic [7:0] pw_byte_o,
	output logic pw_byte_valid_o,
	// Status.
	output logic idle_o
);
	sbsc_state_t st, next_st;
	sbsc_rx_t rx;
	sbsc_tx_t tx, next_tx;
	logic tx_ready;
	logic [1:0] err_cnt, next_err_cnt;
	logic [7:0] err_code, next_err_code;
	logic [2:0] addr_cnt, next_addr_cnt;
	logic [47:0] addr_sh, next_addr_sh;
	logic [7:0] pwb, next_pwb;
	logic pwv, next_pwv;
	logic tx_pend;

	// Acceptable matching byte checks.
	function automatic logic is_match1(input logic [7:0] b);
		is_match1 = (b == `SBSC_MATCH1_A) || (b == `SBSC_MATCH1_B);
	endfunction
	function automatic logic is_match2(input logic [7:0] b);
		is_match2 = (b == `SBSC_MATCH2_A) || (b == `SBSC_MATCH2_B);
	endfunction

	sbsc_uart sbsc_uart_inst (
		.clk_sys_i(clk_sys_i),
		.nrst_i(nrst_i),
		.rxd_i(rxd_i),
		.txd_o(txd_o),
		.tx_i(tx),
		.tx_ready_o(tx_ready),
		.rx_o(rx),
		.rate_locked_o()
	);

	assign tx_pend = tx.valid || !tx_ready;

	// Command sequencing.
	always_comb begin
		next_st = st;
		next_tx = '0;
		next_err_cnt = err_cnt;
		next_err_code = err_code;
		next_addr_cnt = addr_cnt;
		next_addr_sh = addr_sh;
		next_pwb = pwb;
		next_pwv = 1'b0;
		case (st)
			SBSC_ST_SYNC1: begin
				if (rx.valid) begin
					if (!rx.frame_err && is_match1(rx.data)) begin
						next_tx = '{valid: 1'b1, data: rx.data};
						next_st = SBSC_ST_SYNC2;
					end else begin
						next_st = SBSC_ST_IDLE;
					end
				end
			end
			SBSC_ST_SYNC2: begin
				if (rx.valid) begin
					if (!rx.frame_err && !rx.overrun && is_match2(rx.data)) begin
						next_tx = '{valid: 1'b1, data: rx.data};
						next_st = SBSC_ST_CMD;
					end else begin
						next_st = SBSC_ST_IDLE;
					end
				end
			end
			SBSC_ST_CMD: begin
				if (rx.valid) begin
					next_err_cnt = '0;
					if (rx.frame_err) begin
						next_err_code = `SBSC_ERR_FRM;
						next_st = SBSC_ST_ERR;
					end else if (rx.overrun) begin
						next_err_code = `SBSC_ERR_OVR;
						next_st = SBSC_ST_ERR;
					end else if (rx.data == `SBSC_CMD_EMU) begin
						next_tx = '{valid: 1'b1, data: rx.data};
						next_st = SBSC_ST_EMU_VAL;
					end else if (rx.data == `SBSC_CMD_SEC) begin
						next_tx = '{valid: 1'b1, data: rx.data};
						next_addr_cnt = '0;
						next_st = flash_blank_i ? SBSC_ST_IDLE : SBSC_ST_ADDR;
					end else begin
						next_err_code = `SBSC_ERR_CMD;
						next_st = SBSC_ST_ERR;
					end
				end
			end
			SBSC_ST_EMU_VAL: begin
				if (rx.valid) begin
					if (rx.frame_err || rx.overrun) begin
						next_st = SBSC_ST_IDLE;
					end else begin
						next_tx = '{valid: 1'b1, data: `SBSC_ACK_EMU};
						next_st = SBSC_ST_CMD;
					end
				end
			end
			SBSC_ST_ADDR: begin
				// Address bytes are shifted in high first and never answered.
				if (rx.valid) begin
					if (rx.frame_err || rx.overrun) begin
						next_st = SBSC_ST_IDLE;
					end else begin
						next_addr_sh = {addr_sh[39:0], rx.data};
						next_addr_cnt = addr_cnt + 3'h1;
						if (addr_cnt == `SBSC_ADDR_BYTES - 3'h1) begin
							next_st = SBSC_ST_PW;
						end
					end
				end
			end
			SBSC_ST_PW: begin
				if (rx.valid) begin
					if (rx.frame_err || rx.overrun) begin
						next_st = SBSC_ST_IDLE;
					end else begin
						next_pwb = rx.data;
						next_pwv = 1'b1;
					end
				end else if (pw_done_i) begin
					if (pw_ok_i) begin
						next_tx = '{valid: 1'b1, data: `SBSC_ACK_SEC};
						next_st = SBSC_ST_CMD;
					end else begin
						next_st = SBSC_ST_IDLE;
					end
				end
			end
			SBSC_ST_ERR: begin
				// Three identical error bytes, then silence until reset.
				if (!tx_pend) begin
					next_tx = '{valid: 1'b1, data: err_code};
					next_err_cnt = err_cnt + 2'h1;
					if (err_cnt == `SBSC_ERR_REPEAT - 2'h1) begin
						next_st = SBSC_ST_IDLE;
					end
				end
			end
			SBSC_ST_IDLE: next_st = SBSC_ST_IDLE;
			default: next_st = SBSC_ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st <= SBSC_ST_SYNC1;
			tx <= '0;
			err_cnt <= '0;
			err_code <= 8'h00;
			addr_cnt <= '0;
			addr_sh <= '0;
			pwb <= 8'h00;
			pwv <= 1'b0;
		end else begin
			st <= next_st;
			tx <= next_tx;
			err_cnt <= next_err_cnt;
			err_code <= next_err_code;
			addr_cnt <= next_addr_cnt;
			addr_sh <= next_addr_sh;
			pwb <= next_pwb;
			pwv <= next_pwv;
		end
	end

	assign pw_count_addr_o = addr_sh[47:24];
	assign pw_cmp_addr_o = addr_sh[23:0];
	assign pw_byte_o = pwb;
	assign pw_byte_valid_o = pwv;
	assign idle_o = (st == SBSC_ST_IDLE);

	// Checks.
	sequence s_bad_cmd;
		st == SBSC_ST_CMD && rx.valid && !rx.frame_err && !rx.overrun
			&& rx.data != `SBSC_CMD_EMU && rx.data != `SBSC_CMD_SEC;
	endsequence
	a_bad_cmd_err: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		s_bad_cmd |=> st == SBSC_ST_ERR && err_code == `SBSC_ERR_CMD)
		else $error("bad command did not raise command error");
	a_frm_code: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		st == SBSC_ST_CMD && rx.valid && rx.frame_err |=> err_code == `SBSC_ERR_FRM)
		else $error("framing error code wrong");
	a_sync1_echo: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		st == SBSC_ST_SYNC1 && rx.valid && !rx.frame_err && is_match1(rx.data)
		|=> tx.valid && tx.data == $past(rx.data))
		else $error("first matching byte not echoed");
	a_sync2_echo: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		st == SBSC_ST_SYNC2 && rx.valid && !rx.frame_err && !rx.overrun && is_match2(rx.data)
		|=> tx.valid && st == SBSC_ST_CMD)
		else $error("second matching byte not echoed");
	a_emu_echo: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		st == SBSC_ST_CMD && rx.valid && !rx.frame_err && !rx.overrun && rx.data == `SBSC_CMD_EMU
		|=> tx.valid && tx.data == `SBSC_CMD_EMU && st == SBSC_ST_EMU_VAL)
		else $error("emulation command not echoed");
	a_emu_ack: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		st == SBSC_ST_EMU_VAL && rx.valid && !rx.frame_err && !rx.overrun
		|=> tx.valid && tx.data == `SBSC_ACK_EMU && st == SBSC_ST_CMD)
		else $error("set value not answered");
	a_addr_silent: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		st == SBSC_ST_ADDR |=> !tx.valid)
		else $error("address byte answered");
	a_pw_fail_idle: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		st == SBSC_ST_PW && !rx.valid && pw_done_i && !pw_ok_i |=> idle_o && !tx.valid)
		else $error("password mismatch not idle");
	a_rx_err_idle: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		(st == SBSC_ST_ADDR || st == SBSC_ST_PW) && rx.valid && (rx.frame_err || rx.overrun)
		|=> idle_o)
		else $error("receive error not idle");
	a_pw_ok_ack: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		st == SBSC_ST_PW && !rx.valid && pw_done_i && pw_ok_i
		|=> tx.valid && tx.data == `SBSC_ACK_SEC ##1 st == SBSC_ST_CMD)
		else $error("password pass not confirmed");
	sequence s_sec_accept;
		st == SBSC_ST_CMD && rx.valid && !rx.frame_err && !rx.overrun
			&& rx.data == `SBSC_CMD_SEC;
	endsequence
	a_sec_echo: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		s_sec_accept |=> tx.valid && tx.data == `SBSC_CMD_SEC)
		else $error("security command not echoed");
	a_blank_idle: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		st == SBSC_ST_CMD && rx.valid && !rx.frame_err && !rx.overrun
		&& rx.data == `SBSC_CMD_SEC && flash_blank_i |=> idle_o)
		else $error("blank part did not go idle");
	a_idle_silent: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
		st == SBSC_ST_IDLE |=> !tx.valid && idle_o)
		else $error("idle device transmitted");
endmodule
`default_nettype wire

// ===== tb/sbsc_ctrl_model.sv
// Programming controller model that speaks the byte link to the device.
`timescale 1ns/1ps
`default_nettype none
module sbsc_ctrl_model #(
	parameter int BIT_CLKS = 24
) (
	// Clock.
	input wire logic clk_i,
	// Serial lines.
	output logic line_o,
	input wire logic line_i
);
	logic [7:0] rx_byte;
	logic [7:0] rx_q[$];

	// The line idles high, as a pulled-up link does between frames.
	initial line_o = 1'b1;

	// Sends one frame LSB first, every bit at the one fixed rate; a low stop bit makes a framing fault.
	task automatic send(input logic [7:0] b, input logic stop);
		logic [9:0] f;
		f = {stop, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			line_o = f[i];
			repeat (BIT_CLKS) @(negedge clk_i);
		end
		line_o = 1'b1;
	endtask

	// Collects every frame the device sends, sampled mid-bit at the adjusted rate.
	always begin
		@(negedge line_i);
		repeat (BIT_CLKS / 2) @(posedge clk_i);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CLKS) @(posedge clk_i);
			rx_byte[i] = line_i;
		end
		rx_q.push_back(rx_byte);
		repeat (BIT_CLKS) @(posedge clk_i);
	end
endmodule
`default_nettype wire

// ===== tb/serial_boot_security_command_test.sv
// Self-checking bench for the serial boot security command handler.
`timescale 1ns/1ps
`default_nettype none
module serial_boot_security_command_test
	import sbsc_pkg::*;
;
	localparam int BIT_CLKS = 24;
	logic clk_sys_i, nrst_i, rxd_i, txd_o, flash_blank_i, pw_done_i, pw_ok_i;
	logic [23:0] pw_count_addr_o, pw_cmp_addr_o;
	logic [7:0] pw_byte_o;
	logic pw_byte_valid_o, idle_o;
	int num_errors = 0;
	int num_checks = 0;
	int pulses = 0;
	int cycles = 0;
	logic [7:0] exp_q[$];

	sbsc_top sbsc_top_inst (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .rxd_i(rxd_i),
		.txd_o(txd_o), .flash_blank_i(flash_blank_i), .pw_done_i(pw_done_i),
		.pw_ok_i(pw_ok_i), .pw_count_addr_o(pw_count_addr_o), .pw_cmp_addr_o(pw_cmp_addr_o),
		.pw_byte_o(pw_byte_o), .pw_byte_valid_o(pw_byte_valid_o), .idle_o(idle_o));
	sbsc_ctrl_model #(.BIT_CLKS(BIT_CLKS)) sbsc_ctrl_model_inst (.clk_i(clk_sys_i),
		.line_o(rxd_i), .line_i(txd_o));

	// Clock at 100 MHz.
	initial begin
		clk_sys_i = 1'b0;
		forever #5 clk_sys_i = ~clk_sys_i;
	end

	// Counts password byte strobes and cuts a hang short.
	always @(posedge clk_sys_i) begin
		cycles++;
		if (pw_byte_valid_o === 1'b1) pulses++;
		if (cycles == 100000) begin
			num_errors++;
			summarize();
		end
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			num_errors++;
		end
	endtask

	// Sends a byte, then leaves the reply slot free before anything else goes out.
	task automatic send(input logic [7:0] b, input logic stop = 1'b1, input int gap = 12);
		sbsc_ctrl_model_inst.send(b, stop);
		repeat (gap * BIT_CLKS) @(negedge clk_sys_i);
	endtask

	// Compares everything the device sent with what was expected, then clears both.
	task automatic check_rx();
		check(sbsc_ctrl_model_inst.rx_q.size(), exp_q.size());
		foreach (exp_q[i]) begin
			if (i < sbsc_ctrl_model_inst.rx_q.size()) check(sbsc_ctrl_model_inst.rx_q[i], exp_q[i]);
		end
		exp_q.delete();
		sbsc_ctrl_model_inst.rx_q.delete();
	endtask

	task automatic do_reset();
		nrst_i = 1'b0;
		repeat (6) @(negedge clk_sys_i);
		nrst_i = 1'b1;
		exp_q.delete();
		sbsc_ctrl_model_inst.rx_q.delete();
		pulses = 0;
		repeat (2) @(negedge clk_sys_i);
	endtask

	task automatic sync(input logic [7:0] m1, input logic [7:0] m2);
		send(m1);
		send(m2);
		exp_q.push_back(m1);
		exp_q.push_back(m2);
	endtask

	task automatic sec_head(input logic [7:0] m1, input logic [7:0] m2);
		sync(m1, m2);
		send(8'hfa);
		exp_q.push_back(8'hfa);
		for (int i = 1; i <= 6; i++) send(8'(8'h11 * i));
	endtask

	task automatic t_emu();
		do_reset();
		sync(8'h86, 8'h79);
		send(8'hd0);
		send(8'h5a);
		send(8'hd0);
		send(8'h00);
		exp_q = {8'h86, 8'h79, 8'hd0, 8'hd1, 8'hd0, 8'hd1};
		check_rx();
		check(idle_o, 1'b0);
	endtask

	task automatic t_sec_ok();
		do_reset();
		sec_head(8'h30, 8'hcf);
		check_rx();
		check(pw_count_addr_o, 24'h112233);
		check(pw_cmp_addr_o, 24'h445566);
		send(8'ha5);
		check(pw_byte_o, 8'ha5);
		send(8'h3c);
		check(pulses, 2);
		pw_done_i = 1'b1;
		pw_ok_i = 1'b1;
		@(negedge clk_sys_i);
		pw_done_i = 1'b0;
		pw_ok_i = 1'b0;
		repeat (12 * BIT_CLKS) @(negedge clk_sys_i);
		send(8'hd0);
		send(8'h01);
		exp_q = {8'hfb, 8'hd0, 8'hd1};
		check_rx();
	endtask

	task automatic t_pw_fail();
		do_reset();
		sec_head(8'h86, 8'hcf);
		send(8'h77);
		pw_done_i = 1'b1;
		@(negedge clk_sys_i);
		pw_done_i = 1'b0;
		repeat (12 * BIT_CLKS) @(negedge clk_sys_i);
		send(8'hd0);
		check_rx();
		check(idle_o, 1'b1);
	endtask

	task automatic t_blank();
		do_reset();
		flash_blank_i = 1'b1;
		sync(8'h30, 8'h79);
		send(8'hfa);
		send(8'h01);
		exp_q.push_back(8'hfa);
		check_rx();
		check(idle_o, 1'b1);
		flash_blank_i = 1'b0;
	endtask

	// A refused command and a framed-wrong command each give three code bytes, then silence.
	task automatic t_bad_cmd();
		logic [7:0] cmd[2] = '{8'h12, 8'hd0};
		logic stp[2] = '{1'b1, 1'b0};
		logic [7:0] code[2] = '{8'h63, 8'ha1};
		for (int k = 0; k < 2; k++) begin
			do_reset();
			sync(8'h86, 8'h79);
			send(cmd[k], stp[k], 34);
			send(8'hd0);
			exp_q.push_back(code[k]);
			exp_q.push_back(code[k]);
			exp_q.push_back(code[k]);
			check_rx();
			check(idle_o, 1'b1);
		end
	endtask

	task automatic t_bad_sync();
		do_reset();
		send(8'h86);
		send(8'h55);
		send(8'hd0);
		exp_q.push_back(8'h86);
		check_rx();
		check(idle_o, 1'b1);
	endtask

	task automatic t_addr_err();
		do_reset();
		sync(8'h86, 8'h79);
		send(8'hfa);
		send(8'h11);
		send(8'h22, 1'b0);
		send(8'hd0);
		exp_q.push_back(8'hfa);
		check_rx();
		check(idle_o, 1'b1);
	endtask

	task automatic summarize();
		if (num_errors == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Main sequence.
	initial begin
		nrst_i = 1'b0;
		flash_blank_i = 1'b0;
		pw_done_i = 1'b0;
		pw_ok_i = 1'b0;
		t_emu();
		t_sec_ok();
		t_pw_fail();
		t_blank();
		t_bad_cmd();
		t_bad_sync();
		t_addr_err();
		summarize();
	end
endmodule
`default_nettype wire
